// ---- fhs_device_end.sv ----
// Switch-core end: packs extraction headers, checks and unpacks injection headers
// Every link output is a flop. A header moves on the edge at which valid
// and ready are both high; the sender holds it unchanged until that edge.
// Extraction runs request, buffer, link stage: a header reaches the link
// one edge after it is taken. Injection has one holding stage whose empty
// flag is the link ready, so the core must release each header first.

module fhs_device_end #(
  parameter int FIFO_DEPTH = fhs_pkg::FHS_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Link toward the CPU side
  fhs_link_if.dev link,
  // Extraction request from the switch core
  input wire logic ext_req_valid,
  output logic ext_req_ready,
  input wire logic [fhs_pkg::FHS_HDR_W-1:0] ext_req_base,
  input wire fhs_pkg::fhs_slice_t ext_req_fields,
  input wire logic ext_req_encap,
  // Injected header delivered to the switch core
  output logic inj_out_valid,
  input wire logic inj_out_ready,
  output logic [fhs_pkg::FHS_HDR_W-1:0] inj_out_hdr,
  output fhs_pkg::fhs_slice_t inj_out_fields,
  output logic inj_out_encap,
  output logic [fhs_pkg::FHS_CVID_W-1:0] inj_out_cvid,
  // Injection header checks
  output logic inj_out_reserved_error,
  output logic inj_out_leg_error,
  output logic inj_out_kind_error
);
  import fhs_pkg::*;

  // One extra bit carries the encapsulation mode through the buffer
  localparam int FW = FHS_HDR_W + 1;

  // Extraction path: pack, buffer, then a register stage onto the link
  logic [FW-1:0] fifo_in_data;
  logic [FW-1:0] fifo_out_data;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic ext_valid_reg, ext_valid_next;
  logic [FHS_HDR_W-1:0] ext_hdr_reg, ext_hdr_next;
  logic ext_encap_reg, ext_encap_next;

  // Routed flag only survives packing because this is the extraction direction
  assign fifo_in_data = {ext_req_encap,
                         fhs_pack(ext_req_base, ext_req_fields, ext_req_encap, 1'b1)};
  assign ext_req_ready = fifo_in_ready;

  // Absorbs bursts from the core while the CPU end is slow to drain
  fhs_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_ext_fifo (
    .clock(clock),
    .rst(rst),
    .in_valid(ext_req_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // Drain the buffer whenever the link stage is empty or being emptied
  assign fifo_out_ready = ~ext_valid_reg | link.ext_ready;

  // The stage is only refilled once its header has been taken,
  // so none is lost or offered twice
  always_comb begin
    ext_valid_next = ext_valid_reg;
    ext_hdr_next = ext_hdr_reg;
    ext_encap_next = ext_encap_reg;
    if (fifo_out_ready) begin
      ext_valid_next = fifo_out_valid;
      if (fifo_out_valid) begin
        ext_hdr_next = fifo_out_data[FHS_HDR_W-1:0];
        ext_encap_next = fifo_out_data[FW-1];
      end
    end
  end

  // Link stage resets empty: nothing is offered before reset ends
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ext_valid_reg <= 1'b0;
      ext_hdr_reg <= '0;
      ext_encap_reg <= 1'b0;
    end else begin
      ext_valid_reg <= ext_valid_next;
      ext_hdr_reg <= ext_hdr_next;
      ext_encap_reg <= ext_encap_next;
    end
  end

  // Link outputs straight from the stage flops
  assign link.ext_valid = ext_valid_reg;
  assign link.ext_hdr = ext_hdr_reg;
  assign link.ext_encap = ext_encap_reg;

  // Injection path: one-deep holding stage; link ready is the empty flag.
  // Costs every other cycle on back-to-back injections but keeps ready a flop.
  logic inj_valid_reg, inj_valid_next;
  logic inj_ready_reg, inj_ready_next;
  logic [FHS_HDR_W-1:0] inj_hdr_reg, inj_hdr_next;
  fhs_slice_t inj_fields_reg, inj_fields_next;
  logic inj_encap_reg, inj_encap_next;
  logic [FHS_CVID_W-1:0] inj_cvid_reg, inj_cvid_next;
  // Error flags travel with their header and are replaced by the next take
  logic inj_reserved_err_reg, inj_reserved_err_next;
  logic inj_leg_err_reg, inj_leg_err_next;
  logic inj_kind_err_reg, inj_kind_err_next;
  logic inj_take;
  fhs_slice_t inj_decoded;

  // Only an empty stage takes, so a held header is never overwritten
  assign inj_take = link.inj_valid & inj_ready_reg;
  // Routed flag means nothing on injection, so it is dropped here
  assign inj_decoded = fhs_unpack(link.inj_hdr, link.inj_encap, 1'b0);

  always_comb begin
    inj_valid_next = inj_valid_reg;
    inj_hdr_next = inj_hdr_reg;
    inj_fields_next = inj_fields_reg;
    inj_encap_next = inj_encap_reg;
    inj_cvid_next = inj_cvid_reg;
    inj_reserved_err_next = inj_reserved_err_reg;
    inj_leg_err_next = inj_leg_err_reg;
    inj_kind_err_next = inj_kind_err_reg;
    // Release and take never meet: a take needs an empty stage
    if (inj_valid_reg && inj_out_ready) begin
      inj_valid_next = 1'b0;
    end
    if (inj_take) begin
      inj_valid_next = 1'b1;
      inj_hdr_next = link.inj_hdr;
      // Selector picks the meaning of the ten-bit value
      inj_fields_next = inj_decoded;
      inj_encap_next = link.inj_encap;
      // Extension bit weighs 4096 above the tag VLAN value
      inj_cvid_next = fhs_classified_vid(link.inj_hdr);
      // The injector is trusted to clear bit 219; a set bit is only reported
      inj_reserved_err_next = link.inj_hdr[FHS_RESERVED_POS];
      inj_leg_err_next = link.inj_encap &&
                         (inj_decoded.leg_value_selector == FHS_LEG_RESERVED);
      inj_kind_err_next = fhs_pdu_kind_bad(inj_decoded.pdu_kind);
    end
    // Ready is the empty flag of the stage, rising on the edge that releases
    inj_ready_next = ~inj_valid_next;
  end

  // Registers only; all decisions are made in the process above
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      inj_valid_reg <= 1'b0;
      inj_ready_reg <= 1'b0;
      inj_hdr_reg <= '0;
      inj_fields_reg <= '0;
      inj_encap_reg <= 1'b0;
      inj_cvid_reg <= '0;
      inj_reserved_err_reg <= 1'b0;
      inj_leg_err_reg <= 1'b0;
      inj_kind_err_reg <= 1'b0;
    end else begin
      inj_valid_reg <= inj_valid_next;
      inj_ready_reg <= inj_ready_next;
      inj_hdr_reg <= inj_hdr_next;
      inj_fields_reg <= inj_fields_next;
      inj_encap_reg <= inj_encap_next;
      inj_cvid_reg <= inj_cvid_next;
      inj_reserved_err_reg <= inj_reserved_err_next;
      inj_leg_err_reg <= inj_leg_err_next;
      inj_kind_err_reg <= inj_kind_err_next;
    end
  end

  // Outputs straight from the holding stage flops
  assign link.inj_ready = inj_ready_reg;
  assign inj_out_valid = inj_valid_reg;
  assign inj_out_hdr = inj_hdr_reg;
  assign inj_out_fields = inj_fields_reg;
  assign inj_out_encap = inj_encap_reg;
  assign inj_out_cvid = inj_cvid_reg;
  assign inj_out_reserved_error = inj_reserved_err_reg;
  assign inj_out_leg_error = inj_leg_err_reg;
  assign inj_out_kind_error = inj_kind_err_reg;
endmodule

// ---- fhs_pkg.sv ----
// Bit layout, codes and pack/unpack helpers for the header slice 231:191
package fhs_pkg;
  localparam int FHS_HDR_BYTES = 36;
  localparam int FHS_HDR_W = FHS_HDR_BYTES * 8;
  localparam int FHS_FIFO_DEPTH = 16;

  // Field positions (most significant bit of each field)
  localparam int FHS_LEG_SEL_MSB = 231;
  localparam int FHS_LEG_VAL_MSB = 229;
  localparam int FHS_RESERVED_POS = 219;
  localparam int FHS_ROUTED_POS = 218;
  localparam int FHS_SWAP_POS = 217;
  localparam int FHS_TPID_MSB = 216;
  localparam int FHS_VLAN_ID_MSB = 214;
  localparam int FHS_VID_EXT_POS = 202;
  localparam int FHS_PROT_POS = 201;
  localparam int FHS_PDU_OFF_MSB = 200;
  localparam int FHS_PDU_KIND_MSB = 194;
  // Tag VLAN field lives outside the slice; its place is fixed here
  localparam int FHS_TAG_VID_MSB = 11;

  // Field widths
  localparam int FHS_LEG_SEL_W = 2;
  localparam int FHS_LEG_VAL_W = 10;
  localparam int FHS_TPID_W = 2;
  localparam int FHS_VID_W = 12;
  localparam int FHS_PDU_OFF_W = 6;
  localparam int FHS_PDU_KIND_W = 4;
  localparam int FHS_CVID_W = 13;
  localparam logic [FHS_CVID_W-1:0] FHS_VID_EXT_WEIGHT = 13'h1000;

  typedef enum logic [1:0] {
    FHS_LEG_RESERVED = 2'h0,
    FHS_LEG_TUNNEL = 2'h1,
    FHS_LEG_INGRESS = 2'h2,
    FHS_LEG_EGRESS = 2'h3
  } fhs_leg_sel_t;

  typedef enum logic [1:0] {
    FHS_TPID_STANDARD = 2'h0,
    FHS_TPID_CUSTOM1 = 2'h1,
    FHS_TPID_CUSTOM2 = 2'h2,
    FHS_TPID_CUSTOM3 = 2'h3
  } fhs_tpid_t;

  typedef enum logic [3:0] {
    FHS_PDU_NONE = 4'h0,
    FHS_PDU_Y1731_OAM = 4'h1,
    FHS_PDU_MPLS_TP_OAM = 4'h2,
    FHS_PDU_TWAMP = 4'h3,
    FHS_PDU_IP_BFD = 4'h4,
    FHS_PDU_PTP = 4'h5,
    FHS_PDU_IP4_UDP_PTP = 4'h6,
    FHS_PDU_IP6_UDP_PTP = 4'h7,
    FHS_PDU_RESERVED = 4'h8,
    FHS_PDU_SAM_SEQ = 4'h9
  } fhs_pdu_kind_t;

  typedef struct packed {
    fhs_leg_sel_t leg_value_selector;
    logic [FHS_LEG_VAL_W-1:0] leg_or_tunnel_value;
    logic routed_flag;
    logic mac_exchange_request;
    fhs_tpid_t tag_protocol_select;
    logic [FHS_VID_W-1:0] generic_vlan_id;
    logic vlan_id_extension;
    logic protection_flag;
    logic [FHS_PDU_OFF_W-1:0] pdu_halfword_offset;
    fhs_pdu_kind_t pdu_kind;
  } fhs_slice_t;

  // Other header bits pass through from base; leg bits only written when encap
  function automatic logic [FHS_HDR_W-1:0] fhs_pack(input logic [FHS_HDR_W-1:0] base,
                                                     input fhs_slice_t f,
                                                     input logic encap,
                                                     input logic extract);
    logic [FHS_HDR_W-1:0] h;
    h = base;
    if (encap) begin
      h[FHS_LEG_SEL_MSB -: FHS_LEG_SEL_W] = f.leg_value_selector;
      h[FHS_LEG_VAL_MSB -: FHS_LEG_VAL_W] = f.leg_or_tunnel_value;
    end
    h[FHS_RESERVED_POS] = 1'b0;
    h[FHS_ROUTED_POS] = extract & f.routed_flag;
    h[FHS_SWAP_POS] = f.mac_exchange_request;
    h[FHS_TPID_MSB -: FHS_TPID_W] = f.tag_protocol_select;
    h[FHS_VLAN_ID_MSB -: FHS_VID_W] = f.generic_vlan_id;
    h[FHS_VID_EXT_POS] = f.vlan_id_extension;
    h[FHS_PROT_POS] = f.protection_flag;
    h[FHS_PDU_OFF_MSB -: FHS_PDU_OFF_W] = f.pdu_halfword_offset;
    h[FHS_PDU_KIND_MSB -: FHS_PDU_KIND_W] = f.pdu_kind;
    return h;
  endfunction

  function automatic fhs_slice_t fhs_unpack(input logic [FHS_HDR_W-1:0] h,
                                            input logic encap,
                                            input logic extract);
    fhs_slice_t f;
    f.leg_value_selector = encap ? fhs_leg_sel_t'(h[FHS_LEG_SEL_MSB -: FHS_LEG_SEL_W])
                                 : FHS_LEG_RESERVED;
    f.leg_or_tunnel_value = encap ? h[FHS_LEG_VAL_MSB -: FHS_LEG_VAL_W] : '0;
    f.routed_flag = extract & h[FHS_ROUTED_POS];
    f.mac_exchange_request = h[FHS_SWAP_POS];
    f.tag_protocol_select = fhs_tpid_t'(h[FHS_TPID_MSB -: FHS_TPID_W]);
    f.generic_vlan_id = h[FHS_VLAN_ID_MSB -: FHS_VID_W];
    f.vlan_id_extension = h[FHS_VID_EXT_POS];
    f.protection_flag = h[FHS_PROT_POS];
    f.pdu_halfword_offset = h[FHS_PDU_OFF_MSB -: FHS_PDU_OFF_W];
    f.pdu_kind = fhs_pdu_kind_t'(h[FHS_PDU_KIND_MSB -: FHS_PDU_KIND_W]);
    return f;
  endfunction

  function automatic logic [FHS_CVID_W-1:0] fhs_classified_vid(input logic [FHS_HDR_W-1:0] h);
    logic [FHS_CVID_W-1:0] v;
    v = (h[FHS_VID_EXT_POS] ? FHS_VID_EXT_WEIGHT : 13'h0000) +
        {1'b0, h[FHS_TAG_VID_MSB -: FHS_VID_W]};
    return v;
  endfunction

  function automatic logic fhs_pdu_kind_bad(input logic [FHS_PDU_KIND_W-1:0] k);
    return (k == FHS_PDU_RESERVED) || (k > FHS_PDU_SAM_SEQ);
  endfunction
endpackage

// ---- fhs_link_if.sv ----
// Link carrying complete headers between the switch core and the CPU side
interface fhs_link_if;
  import fhs_pkg::*;
  // Injection: CPU side to switch core
  logic inj_valid;
  logic inj_ready;
  logic [FHS_HDR_W-1:0] inj_hdr;
  logic inj_encap;
  // Extraction: switch core to CPU side
  logic ext_valid;
  logic ext_ready;
  logic [FHS_HDR_W-1:0] ext_hdr;
  logic ext_encap;

  modport dev (
    input inj_valid, inj_hdr, inj_encap, ext_ready,
    output inj_ready, ext_valid, ext_hdr, ext_encap
  );
  modport cpu (
    output inj_valid, inj_hdr, inj_encap, ext_ready,
    input inj_ready, ext_valid, ext_hdr, ext_encap
  );
endinterface

// ---- fhs_fifo.sv ----
// Synchronous FIFO with valid/ready on both sides; DEPTH must be a power of two
module fhs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg, wr_ptr_next;
  logic [AW-1:0] rd_ptr_reg, rd_ptr_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic in_ready_reg, in_ready_next;
  logic out_valid_reg, out_valid_next;
  logic push, pop;

  assign push = in_valid & in_ready_reg;
  assign pop = out_ready & out_valid_reg;
  assign in_ready = in_ready_reg;
  assign out_valid = out_valid_reg;
  assign out_data = mem[rd_ptr_reg];

  always_comb begin
    wr_ptr_next = push ? wr_ptr_reg + AW'(1) : wr_ptr_reg;
    rd_ptr_next = pop ? rd_ptr_reg + AW'(1) : rd_ptr_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    // Full and empty are registered so in_ready and out_valid come from flops
    in_ready_next = cnt_next != FULL_COUNT;
    out_valid_next = cnt_next != '0;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
      in_ready_reg <= 1'b0;
      out_valid_reg <= 1'b0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      cnt_reg <= cnt_next;
      in_ready_reg <= in_ready_next;
      out_valid_reg <= out_valid_next;
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end
endmodule

// ---- fhs_cpu_end.sv ----
// CPU end: builds injection headers and unpacks extraction headers
module fhs_cpu_end (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Link toward the switch core
  fhs_link_if.cpu link,
  // Injection request from software
  input wire logic inj_req_valid,
  output logic inj_req_ready,
  input wire logic [fhs_pkg::FHS_HDR_W-1:0] inj_req_base,
  input wire fhs_pkg::fhs_slice_t inj_req_fields,
  input wire logic inj_req_encap,
  // Extracted header delivered to software
  output logic ext_out_valid,
  input wire logic ext_out_ready,
  output fhs_pkg::fhs_slice_t ext_out_fields,
  output logic ext_out_encap,
  output logic [fhs_pkg::FHS_CVID_W-1:0] ext_out_cvid,
  output logic ext_out_kind_error
);
  import fhs_pkg::*;

  logic inj_valid_reg, inj_valid_next;
  logic [FHS_HDR_W-1:0] inj_hdr_reg, inj_hdr_next;
  logic inj_encap_reg, inj_encap_next;
  logic ext_valid_reg, ext_valid_next;
  fhs_slice_t ext_fields_reg, ext_fields_next;
  logic ext_encap_reg, ext_encap_next;
  logic [FHS_CVID_W-1:0] ext_cvid_reg, ext_cvid_next;
  logic ext_kind_err_reg, ext_kind_err_next;
  logic ext_take;

  assign ext_take = link.ext_valid & ~ext_valid_reg;

  always_comb begin
    inj_valid_next = inj_valid_reg;
    inj_hdr_next = inj_hdr_reg;
    inj_encap_next = inj_encap_reg;
    if (inj_valid_reg && link.inj_ready) begin
      inj_valid_next = 1'b0;
    end
    if (inj_req_valid && !inj_valid_reg) begin
      inj_valid_next = 1'b1;
      // Reserved bit forced low, routed bit also forced low on injection
      inj_hdr_next = fhs_pack(inj_req_base, inj_req_fields, inj_req_encap, 1'b0);
      inj_encap_next = inj_req_encap;
    end
    ext_valid_next = ext_valid_reg;
    ext_fields_next = ext_fields_reg;
    ext_encap_next = ext_encap_reg;
    ext_cvid_next = ext_cvid_reg;
    ext_kind_err_next = ext_kind_err_reg;
    if (ext_valid_reg && ext_out_ready) begin
      ext_valid_next = 1'b0;
    end
    if (ext_take) begin
      ext_valid_next = 1'b1;
      ext_fields_next = fhs_unpack(link.ext_hdr, link.ext_encap, 1'b1);
      ext_encap_next = link.ext_encap;
      ext_cvid_next = fhs_classified_vid(link.ext_hdr);
      ext_kind_err_next =
          fhs_pdu_kind_bad(link.ext_hdr[FHS_PDU_KIND_MSB -: FHS_PDU_KIND_W]);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      inj_valid_reg <= 1'b0;
      inj_hdr_reg <= '0;
      inj_encap_reg <= 1'b0;
      ext_valid_reg <= 1'b0;
      ext_fields_reg <= '0;
      ext_encap_reg <= 1'b0;
      ext_cvid_reg <= '0;
      ext_kind_err_reg <= 1'b0;
    end else begin
      inj_valid_reg <= inj_valid_next;
      inj_hdr_reg <= inj_hdr_next;
      inj_encap_reg <= inj_encap_next;
      ext_valid_reg <= ext_valid_next;
      ext_fields_reg <= ext_fields_next;
      ext_encap_reg <= ext_encap_next;
      ext_cvid_reg <= ext_cvid_next;
      ext_kind_err_reg <= ext_kind_err_next;
    end
  end

  assign inj_req_ready = ~inj_valid_reg;
  assign link.inj_valid = inj_valid_reg;
  assign link.inj_hdr = inj_hdr_reg;
  assign link.inj_encap = inj_encap_reg;
  assign link.ext_ready = ~ext_valid_reg;
  assign ext_out_valid = ext_valid_reg;
  assign ext_out_fields = ext_fields_reg;
  assign ext_out_encap = ext_encap_reg;
  assign ext_out_cvid = ext_cvid_reg;
  assign ext_out_kind_error = ext_kind_err_reg;
endmodule

// ---- fhs_link_assertions.sv ----
// Protocol checks on the header link between the switch core and CPU ends
module fhs_link_assertions (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Injection direction
  input wire logic inj_valid,
  input wire logic inj_ready,
  input wire logic [fhs_pkg::FHS_HDR_W-1:0] inj_hdr,
  input wire logic inj_encap,
  // Extraction direction
  input wire logic ext_valid,
  input wire logic ext_ready,
  input wire logic [fhs_pkg::FHS_HDR_W-1:0] ext_hdr,
  input wire logic ext_encap
);
  timeunit 1ns;
  timeprecision 1ps;
  import fhs_pkg::*;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  a_inj_reserved_zero:
    assert property (inj_valid |-> !inj_hdr[FHS_RESERVED_POS])
    else $error("injected header has reserved bit set");
  a_inj_routed_clear:
    assert property (inj_valid |-> !inj_hdr[FHS_ROUTED_POS])
    else $error("injected header carries routed flag");
  a_ext_reserved_zero:
    assert property (ext_valid |-> !ext_hdr[FHS_RESERVED_POS])
    else $error("extracted header has reserved bit set");
  a_inj_hold_stable:
    assert property (inj_valid && !inj_ready |=> inj_valid && $stable(inj_hdr)
                     && $stable(inj_encap))
    else $error("injection header changed while stalled");
  a_ext_hold_stable:
    assert property (ext_valid && !ext_ready |=> ext_valid && $stable(ext_hdr)
                     && $stable(ext_encap))
    else $error("extraction header changed while stalled");
  a_inj_take_once:
    assert property (inj_valid && inj_ready |=> !inj_valid && !inj_ready)
    else $error("injection header taken twice");
  a_ext_take_once:
    assert property (ext_valid && ext_ready |=> !ext_ready)
    else $error("extraction stage did not fill after take");
  a_quiet_after_reset:
    assert property ($fell(rst) |-> !inj_valid && !ext_valid)
    else $error("link valid raised straight out of reset");

  c_inj_stall: cover property (inj_valid && !inj_ready);
  c_ext_stall: cover property (ext_valid && !ext_ready);
  c_ext_encap: cover property (ext_valid && ext_ready && ext_encap);
endmodule

// ---- tb_top.sv ----
// Self-checking bench: both header link ends joined back to back
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fhs_pkg::*;

  logic clock, rst, ext_req_valid, ext_req_ready, ext_req_encap;
  logic inj_out_valid, inj_out_ready, inj_out_encap, reserved_err, leg_err, kind_err;
  logic inj_req_valid, inj_req_ready, inj_req_encap;
  logic ext_out_valid, ext_out_ready, ext_out_encap, ext_kind_err, ok;
  logic [FHS_HDR_W-1:0] ext_req_base, inj_out_hdr, inj_req_base;
  fhs_slice_t ext_req_fields, inj_out_fields, inj_req_fields, ext_out_fields;
  logic [FHS_CVID_W-1:0] inj_out_cvid, ext_out_cvid;
  int num_errors = 0;
  int n_compared = 0;
  int taken;
  localparam int FILL_DEPTH = 4;

  fhs_link_if link ();
  // Small FIFO so the refusal point is reached quickly
  fhs_device_end #(.FIFO_DEPTH(FILL_DEPTH)) fhs_device_end_i (.clock(clock), .rst(rst),
    .link(link), .ext_req_valid(ext_req_valid), .ext_req_ready(ext_req_ready),
    .ext_req_base(ext_req_base), .ext_req_fields(ext_req_fields),
    .ext_req_encap(ext_req_encap), .inj_out_valid(inj_out_valid),
    .inj_out_ready(inj_out_ready), .inj_out_hdr(inj_out_hdr),
    .inj_out_fields(inj_out_fields), .inj_out_encap(inj_out_encap),
    .inj_out_cvid(inj_out_cvid), .inj_out_reserved_error(reserved_err),
    .inj_out_leg_error(leg_err), .inj_out_kind_error(kind_err));
  fhs_cpu_end fhs_cpu_end_i (.clock(clock), .rst(rst), .link(link),
    .inj_req_valid(inj_req_valid), .inj_req_ready(inj_req_ready),
    .inj_req_base(inj_req_base), .inj_req_fields(inj_req_fields),
    .inj_req_encap(inj_req_encap), .ext_out_valid(ext_out_valid),
    .ext_out_ready(ext_out_ready), .ext_out_fields(ext_out_fields),
    .ext_out_encap(ext_out_encap), .ext_out_cvid(ext_out_cvid),
    .ext_out_kind_error(ext_kind_err));
  fhs_link_assertions fhs_link_assertions_i (.clock(clock), .rst(rst),
    .inj_valid(link.inj_valid), .inj_ready(link.inj_ready), .inj_hdr(link.inj_hdr),
    .inj_encap(link.inj_encap), .ext_valid(link.ext_valid), .ext_ready(link.ext_ready),
    .ext_hdr(link.ext_hdr), .ext_encap(link.ext_encap));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Every code of selector, TPID and PDU kind is reached as k sweeps 0..15
  function automatic fhs_slice_t mk(int k, logic routed);
    fhs_slice_t f;
    f.leg_value_selector = fhs_leg_sel_t'(k[1:0]);
    f.leg_or_tunnel_value = 10'h3a5 ^ 10'(k);
    f.routed_flag = routed;
    f.mac_exchange_request = k[0];
    f.tag_protocol_select = fhs_tpid_t'(k[1:0]);
    f.generic_vlan_id = 12'hfff - 12'(k);
    f.vlan_id_extension = k[1];
    f.protection_flag = k[2];
    f.pdu_halfword_offset = 6'h3f - 6'(k);
    f.pdu_kind = fhs_pdu_kind_t'(k[3:0]);
    return f;
  endfunction

  // Base has bits 219 and 218 set so the packer must clear them
  function automatic logic [FHS_HDR_W-1:0] mk_base(int k);
    return {9{32'hadc3_0f69}} ^ FHS_HDR_W'(k);
  endfunction

  function automatic logic enc(int k);
    return (k % 5) != 3;
  endfunction

  function automatic fhs_slice_t exp_f(int k, logic routed);
    fhs_slice_t f;
    f = mk(k, routed);
    if (!enc(k)) begin
      f.leg_value_selector = FHS_LEG_RESERVED;
      f.leg_or_tunnel_value = '0;
    end
    return f;
  endfunction

  function automatic logic [FHS_HDR_W-1:0] exp_hdr(int k);
    logic [FHS_HDR_W-1:0] h;
    logic [39:0] f;
    h = mk_base(k);
    f = mk(k, 1'b1);
    if (enc(k)) begin
      h[231:220] = f[39:28];
    end
    h[219:218] = 2'h0;
    h[217:191] = f[26:0];
    return h;
  endfunction

  function automatic logic [FHS_CVID_W-1:0] exp_cvid(int k);
    logic [FHS_HDR_W-1:0] b;
    b = mk_base(k);
    return {1'b0, b[11:0]} + (k[1] ? 13'h1000 : 13'h0000);
  endfunction

  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(string name, logic [FHS_HDR_W-1:0] exp, logic [FHS_HDR_W-1:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Polls just after each edge; the value seen is what the next edge samples
  task automatic wait_for(string what, ref logic sig, input int lim, output logic hit);
    int n;
    n = 0;
    while (sig !== 1'b1 && n < lim) begin
      @(posedge clock);
      #1;
      n++;
    end
    hit = (sig === 1'b1);
  endtask

  task automatic must(string what, ref logic sig);
    logic hit;
    wait_for(what, sig, 200, hit);
    if (!hit) begin
      num_errors++;
      $display("[FAIL] %s never came", what);
      wrap_up();
    end
  endtask

  task automatic cpu_send(int k);
    inj_req_base = mk_base(k);
    inj_req_fields = mk(k, 1'b1);
    inj_req_encap = enc(k);
    inj_req_valid = 1'b1;
    must("inj_req_ready", inj_req_ready);
    @(posedge clock);
    #1;
    inj_req_valid = 1'b0;
    @(posedge clock);
    #1;
  endtask

  task automatic dev_recv(int k);
    must("inj_out_valid", inj_out_valid);
    chk("inj hdr", exp_hdr(k), inj_out_hdr);
    chk("inj fields", FHS_HDR_W'(exp_f(k, 1'b0)), FHS_HDR_W'(inj_out_fields));
    chk("inj encap", FHS_HDR_W'(enc(k)), FHS_HDR_W'(inj_out_encap));
    chk("inj cvid", FHS_HDR_W'(exp_cvid(k)), FHS_HDR_W'(inj_out_cvid));
    chk("inj reserved err", '0, FHS_HDR_W'(reserved_err));
    chk("inj leg err", FHS_HDR_W'(enc(k) && k[1:0] == 2'h0), FHS_HDR_W'(leg_err));
    chk("inj kind err", FHS_HDR_W'(k == 8 || k > 9), FHS_HDR_W'(kind_err));
    inj_out_ready = 1'b1;
    @(posedge clock);
    #1;
    inj_out_ready = 1'b0;
    @(posedge clock);
    #1;
  endtask

  task automatic dev_send(int k, int lim, output logic hit);
    ext_req_base = mk_base(k);
    ext_req_fields = mk(k, k[0]);
    ext_req_encap = enc(k);
    ext_req_valid = 1'b1;
    wait_for("ext_req_ready", ext_req_ready, lim, hit);
    if (hit) begin
      @(posedge clock);
      #1;
    end
    ext_req_valid = 1'b0;
    @(posedge clock);
    #1;
  endtask

  task automatic cpu_recv(int k);
    must("ext_out_valid", ext_out_valid);
    chk("ext fields", FHS_HDR_W'(exp_f(k, k[0])), FHS_HDR_W'(ext_out_fields));
    chk("ext encap", FHS_HDR_W'(enc(k)), FHS_HDR_W'(ext_out_encap));
    chk("ext cvid", FHS_HDR_W'(exp_cvid(k)), FHS_HDR_W'(ext_out_cvid));
    chk("ext kind err", FHS_HDR_W'(k == 8 || k > 9), FHS_HDR_W'(ext_kind_err));
    ext_out_ready = 1'b1;
    @(posedge clock);
    #1;
    ext_out_ready = 1'b0;
    @(posedge clock);
    #1;
  endtask

  initial begin
    rst = 1'b1;
    {ext_req_valid, ext_req_encap, inj_out_ready, inj_req_valid, inj_req_encap} = '0;
    ext_out_ready = 1'b0;
    ext_req_base = '0;
    inj_req_base = '0;
    ext_req_fields = '0;
    inj_req_fields = '0;
    repeat (20) @(posedge clock);
    #1;
    rst = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    // Two headers in flight so the second stalls on the link
    for (int k = 0; k < 16; k += 2) begin
      cpu_send(k);
      cpu_send(k + 1);
      dev_recv(k);
      dev_recv(k + 1);
    end
    $display("test injection done, mismatches %0d", num_errors);
    for (int k = 0; k < 16; k++) begin
      dev_send(k, 200, ok);
      chk("ext taken", FHS_HDR_W'(1), FHS_HDR_W'(ok));
      cpu_recv(k);
    end
    $display("test extraction done, mismatches %0d", num_errors);
    // CPU end stalls while the core pushes until refused; buffer, link stage
    // and CPU stage then hold FILL_DEPTH + 2 headers
    taken = 0;
    while (ext_req_ready === 1'b1 && taken < 20) begin
      dev_send(taken, 1, ok);
      chk("fill taken", FHS_HDR_W'(1), FHS_HDR_W'(ok));
      taken++;
    end
    chk("fill refused", FHS_HDR_W'(FILL_DEPTH + 2), FHS_HDR_W'(taken));
    for (int k = 0; k < taken; k++) begin
      cpu_recv(k);
    end
    $display("test fill and drain done, mismatches %0d", num_errors);
    wrap_up();
  end
endmodule
